/* File: pmt_consts.svh */
`ifndef PMT_CONSTS_SVH
`define PMT_CONSTS_SVH
// Behaviour
// - Timer ticks at system clock divided by four
// - Count advances from zero per prescaled tick
// - Count equal to period raises match
// - Next tick after match clears count, clocks postscaler
// - Reset clears count, period becomes all ones
// - Count/control writes and reset clear scalers
// - Control write leaves count untouched
// - Postscaler reaching ratio sets match flag
// - Interrupt request only when enable bit set
// - Postscale ratio is code plus one
// - Control bit 2 switches timer on
// - Control bit 7 reads zero
// - Match pulse synchronous, offered to peripherals
// - Sleep stops timer, registers hold
// - Count and period readable and writable
// - Duty reload strobe at count clear
// - Postscaler never alters match timing

// Register byte addresses on APB
`define PMT_ADDR_COUNT    12'h000
`define PMT_ADDR_PERIOD   12'h004
`define PMT_ADDR_CONTROL  12'h008
`define PMT_ADDR_IRQ_REQ  12'h00c
`define PMT_ADDR_IRQ_EN   12'h010
// Field positions
`define PMT_CTL_ON_BIT    2
`define PMT_CTL_PS_LSB    0
`define PMT_CTL_POS_LSB   3
`define PMT_IRQ_BIT       1
// Reset values
`define PMT_COUNT_RST     8'h00
`define PMT_PERIOD_RST    8'hff
`define PMT_CONTROL_RST   7'h00
// Instruction clock divide ratio
`define PMT_INSTR_DIV     4
`endif

/* File: pmt_pkg.sv */
package pmt_pkg;
  typedef logic [7:0] pmt_byte_t;
  typedef enum logic [1:0] {PMT_PS_1, PMT_PS_4, PMT_PS_16, PMT_PS_64}
    pmt_ps_t;
endpackage

/* File: pmt_div.sv */
`timescale 1ns/1ps
// Divider producing a one-cycle enable every DIV cycles while run is high
module pmt_div #(
  parameter int DIV = 4
) (
  input  wire logic sys_clk,   // System clock
  input  wire logic sys_rst,   // Sync reset
  input  wire logic clr,       // Restart count
  input  wire logic run,       // Advance enable
  output logic      tick       // One-cycle enable
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  logic [W-1:0] cnt_r;
  wire last = (cnt_r == W'(DIV - 1));

  assign tick = run & last;

  // Count only while run so the phase holds when stopped
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst || clr)
      cnt_r <= '0;
    else if (run)
      cnt_r <= last ? '0 : cnt_r + 1'b1;
  end
endmodule // pmt_div

/* File: pmt_timer.sv */
`timescale 1ns/1ps
`include "pmt_consts.svh"
module pmt_timer (
  input  wire logic        sys_clk,      // 100 MHz clock
  input  wire logic        sys_rst,      // Sync reset, high
  input  wire logic        soft_rst,     // Other reset source pulse
  input  wire logic        sleep,        // Processor asleep
  input  wire logic        psel,         // APB select
  input  wire logic        penable,      // APB access phase
  input  wire logic        pwrite,       // APB direction
  input  wire logic [11:0] paddr,        // APB byte address
  input  wire logic [31:0] pwdata,       // APB write data
  output logic      [31:0] prdata,       // APB read data
  output logic             pready,       // APB ready
  output logic             pslverr,      // APB error
  output logic             period_match_pulse, // Match to peripherals
  output logic             duty_reload,  // Count clear strobe
  output logic             match_irq     // Gated interrupt request
);
  import pmt_pkg::*;

  // Registers
  pmt_byte_t   timer_count_r;
  pmt_byte_t   period_value_r;
  logic [6:0]  timer_control_r;
  logic        match_irq_flag_r;
  logic        match_irq_enable_r;
  logic [5:0]  pre_cnt_r;
  logic [3:0]  post_cnt_r;
  logic        match_r;
  logic        any_rst;

  // APB decode; every access completes in its first access cycle
  wire acc       = psel & penable;
  wire wr        = acc & pwrite;
  wire hit_cnt   = (paddr == `PMT_ADDR_COUNT);
  wire hit_per   = (paddr == `PMT_ADDR_PERIOD);
  wire hit_ctl   = (paddr == `PMT_ADDR_CONTROL);
  wire hit_req   = (paddr == `PMT_ADDR_IRQ_REQ);
  wire hit_en    = (paddr == `PMT_ADDR_IRQ_EN);
  wire mapped    = hit_cnt | hit_per | hit_ctl | hit_req | hit_en;
  wire wr_cnt    = wr & hit_cnt;
  wire wr_per    = wr & hit_per;
  wire wr_ctl    = wr & hit_ctl;
  wire wr_req    = wr & hit_req;
  wire wr_en     = wr & hit_en;

  assign pready  = 1'b1;
  assign pslverr = acc & ~mapped;
  assign any_rst = sys_rst | soft_rst;

  // Control fields
  wire       timer_on = timer_control_r[`PMT_CTL_ON_BIT];
  wire [1:0] ps_sel   = timer_control_r[`PMT_CTL_PS_LSB +: 2];
  wire [3:0] pos_sel  = timer_control_r[`PMT_CTL_POS_LSB +: 4];

  // Timer runs only when on and awake
  wire run = timer_on & ~sleep;

  // Instruction clock enable, system clock divided by four
  logic instr_tick;
  pmt_div #(
    .DIV (`PMT_INSTR_DIV)
  ) u_instr_div (
    .sys_clk (sys_clk),
    .sys_rst (sys_rst),
    .clr     (soft_rst),                               // Every reset restarts it
    .run     (~sleep),
    .tick    (instr_tick)
  );

  // Scalers clear on count write, control write or any reset
  wire scaler_clr = any_rst | wr_cnt | wr_ctl;

  // Prescaler terminal count by select code
  logic pre_last;
  always_comb
  begin
    unique case (pmt_ps_t'(ps_sel))
      PMT_PS_1:  pre_last = 1'b1;
      PMT_PS_4:  pre_last = (pre_cnt_r[1:0] == 2'h3);
      PMT_PS_16: pre_last = (pre_cnt_r[3:0] == 4'hf);
      PMT_PS_64: pre_last = (pre_cnt_r == 6'h3f);
    endcase
  end

  // Increment strobe; a tick landing on a scaler clear is dropped, so a
  // control write can never move the count in the same cycle
  wire step = run & instr_tick;
  wire inc  = step & pre_last & ~scaler_clr;

  // Prescaler holds when stopped
  always_ff @(posedge sys_clk)
  begin
    if (scaler_clr)
      pre_cnt_r <= '0;
    else if (step)
      pre_cnt_r <= pre_last ? 6'h00 : pre_cnt_r + 6'h01;
  end

  // Comparator; equality alone would hold for a whole tick, so match is
  // qualified with the increment edge to form a single-cycle pulse
  wire equal = (timer_count_r == period_value_r);
  wire match_now = inc & equal;

  // Count: clears on match increment, else advances
  always_ff @(posedge sys_clk)
  begin
    if (any_rst)
      timer_count_r <= `PMT_COUNT_RST;
    else if (wr_cnt)
      timer_count_r <= pwdata[7:0];
    else if (match_now)
      timer_count_r <= `PMT_COUNT_RST;
    else if (inc)
      timer_count_r <= timer_count_r + 8'h01;
  end

  // Period register
  always_ff @(posedge sys_clk)
  begin
    if (any_rst)
      period_value_r <= `PMT_PERIOD_RST;
    else if (wr_per)
      period_value_r <= pwdata[7:0];
  end

  // Control register; count is not touched here
  always_ff @(posedge sys_clk)
  begin
    if (any_rst)
      timer_control_r <= `PMT_CONTROL_RST;
    else if (wr_ctl)
      timer_control_r <= pwdata[6:0];
  end

  // Registered match pulse, one system cycle, lands with the count clear
  always_ff @(posedge sys_clk)
  begin
    if (any_rst)
      match_r <= 1'b0;
    else
      match_r <= match_now;
  end

  assign period_match_pulse = match_r;
  assign duty_reload        = match_r;

  // Postscaler counts matches; ratio is code plus one
  wire post_last = (post_cnt_r == pos_sel);
  always_ff @(posedge sys_clk)
  begin
    if (scaler_clr)
      post_cnt_r <= '0;
    else if (match_r)
      post_cnt_r <= post_last ? 4'h0 : post_cnt_r + 4'h1;
  end

  // Flag rate follows the postscaler; match timing never does
  wire flag_set = match_r & post_last;

  // Flag is sticky; a set wins over a software clear
  always_ff @(posedge sys_clk)
  begin
    if (any_rst)
      match_irq_flag_r <= 1'b0;
    else if (flag_set)
      match_irq_flag_r <= 1'b1;
    else if (wr_req)
      match_irq_flag_r <= pwdata[`PMT_IRQ_BIT];
  end

  // Interrupt enable bit, software owned
  always_ff @(posedge sys_clk)
  begin
    if (any_rst)
      match_irq_enable_r <= 1'b0;
    else if (wr_en)
      match_irq_enable_r <= pwdata[`PMT_IRQ_BIT];
  end

  assign match_irq = match_irq_flag_r & match_irq_enable_r;

  // Read mux; bit 7 of control is always zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_cnt)
      rd_mux = {24'h00_0000, timer_count_r};
    else if (hit_per)
      rd_mux = {24'h00_0000, period_value_r};
    else if (hit_ctl)
      rd_mux = {25'h000_0000, timer_control_r};
    else if (hit_req)
      rd_mux = {30'h0000_0000, match_irq_flag_r, 1'b0};
    else if (hit_en)
      rd_mux = {30'h0000_0000, match_irq_enable_r, 1'b0};
  end

  // Read data from flip-flops, captured in the setup cycle
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      prdata <= 32'h0000_0000;
    else if (psel & ~penable & ~pwrite)
      prdata <= rd_mux;
  end

  // Assertions

  // Match clears the count on the following cycle
  match_clears_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    match_now && !wr_cnt |=> timer_count_r == 8'h00 && period_match_pulse)
    else $error("count not cleared after match");

  // A match pulse follows a cycle of equal count and period
  match_equal_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    period_match_pulse |-> $past(timer_count_r) == $past(period_value_r))
    else $error("match without equality");

  // Stopped timer neither counts nor matches
  off_hold_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    !timer_on && !wr_cnt |=> $stable(timer_count_r) && !period_match_pulse)
    else $error("count moved while off");

  // Sleep freezes both count and period
  sleep_hold_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    sleep && !wr_cnt && !wr_per |=> $stable(timer_count_r)
      && $stable(period_value_r))
    else $error("registers changed in sleep");

  // Control write keeps the count, restarts the prescaler
  ctl_keeps_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    wr_ctl |=> $stable(timer_count_r) && pre_cnt_r == 6'h00)
    else $error("control write disturbed count");

  // Any reset source restores count and period
  rst_vals_a: assert property (
    @(posedge sys_clk)
    any_rst |=> timer_count_r == 8'h00 && period_value_r == 8'hff)
    else $error("bad reset values");

  // Postscaler terminal match latches the flag
  flag_set_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    flag_set |=> match_irq_flag_r)
    else $error("flag not latched");

  // Clearing the enable silences the request
  irq_gate_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    wr_en && !pwdata[`PMT_IRQ_BIT] |=> !match_irq)
    else $error("irq without enable");

  // Match strobe lasts one system cycle
  pulse_one_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    period_match_pulse |=> !period_match_pulse)
    else $error("match pulse too long");

  // Code zero flags every match
  ratio_one_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    match_r && pos_sel == 4'h0 |=> match_irq_flag_r)
    else $error("1:1 postscale missed");

  // Undivided increments are four system cycles apart
  pre_one_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    inc && ps_sel == 2'h0 |=> !inc ##1 !inc ##1 !inc)
    else $error("instruction clock not divided by four");

  // No stray strobe right after a reset
  pulse_rst_a: assert property (
    @(posedge sys_clk)
    any_rst |=> !period_match_pulse)
    else $error("match pulse after reset");

  // Count and control writes and resets leave both scalers at zero
  scaler_clr_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    scaler_clr |=> pre_cnt_r == 6'h00 && post_cnt_r == 4'h0)
    else $error("scaler not cleared");

  // Prescaler keeps its phase while stopped
  pre_hold_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    !run && !scaler_clr |=> $stable(pre_cnt_r))
    else $error("prescaler moved while stopped");

  // Prescaler frozen in sleep
  sleep_pre_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    sleep && !scaler_clr |=> $stable(pre_cnt_r))
    else $error("prescaler moved in sleep");

  // Count write lands as written
  cnt_write_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    wr_cnt |=> timer_count_r == $past(pwdata[7:0]))
    else $error("count write lost");

  // Period write lands as written
  per_write_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    wr_per |=> period_value_r == $past(pwdata[7:0]))
    else $error("period write lost");

  // Increment without match adds exactly one
  inc_step_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    inc && !match_now && !wr_cnt |=>
      timer_count_r == $past(timer_count_r) + 8'h01)
    else $error("count did not step by one");

  // Count moves only on an increment or a write
  no_tick_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    !inc && !wr_cnt |=> $stable(timer_count_r))
    else $error("count moved without tick");

  // Unused control bit reads back as zero
  ctl_bit7_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    psel && !penable && !pwrite && hit_ctl |=> prdata[7] == 1'b0)
    else $error("control bit 7 read as one");

  // Flag sticks until software writes it
  flag_hold_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    match_irq_flag_r && !wr_req |=> match_irq_flag_r)
    else $error("flag dropped on its own");

  // Flag rises only on a postscaler event or a software write
  flag_quiet_a: assert property (
    @(posedge sys_clk) disable iff (any_rst)
    !match_irq_flag_r && !flag_set && !wr_req |=> !match_irq_flag_r)
    else $error("flag rose without match");
endmodule // pmt_timer

/* File: pmt_peer.sv */
`timescale 1ns/1ps
// Consumer of the match strobe, as a PWM or logic cell sees it
module pmt_peer (
  input  wire logic sys_clk,            // System clock
  input  wire logic sys_rst,            // Sync reset
  input  wire logic period_match_pulse, // Match strobe
  input  wire logic duty_reload,        // Duty reload strobe
  output int        gap,                // Cycles between last strobes
  output int        pulses,             // Strobes seen
  output int        faults              // Reload not aligned to match
);
  int cnt;

  // Spacing of strobes; reload must sit on the match
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      cnt <= 0;
      gap <= 0;
      pulses <= 0;
      faults <= 0;
    end
    else
    begin
      cnt <= cnt + 1;
      if (duty_reload !== period_match_pulse)
        faults <= faults + 1;
      if (period_match_pulse === 1'b1)
      begin
        gap <= cnt + 1;
        cnt <= 0;
        pulses <= pulses + 1;
      end
    end
  end
endmodule // pmt_peer

/* File: testbench.sv */
`timescale 1ns/1ps
`include "pmt_consts.svh"
module testbench;
  logic        sys_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        soft_rst = 1'b0;
  logic        sleep = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        period_match_pulse;
  logic        duty_reload;
  logic        match_irq;
  logic [31:0] q;
  logic        e;
  int          n_errors = 0;
  int          tests_run = 0;
  int          gap, pulses, faults, p0, i;
  int          codes [3] = '{0, 3, 15};

  always #5 sys_clk = ~sys_clk;

  pmt_timer i_pmt_timer (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .soft_rst(soft_rst), .sleep(sleep), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .period_match_pulse(period_match_pulse), .duty_reload(duty_reload),
    .match_irq(match_irq));

  pmt_peer i_pmt_peer (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .period_match_pulse(period_match_pulse), .duty_reload(duty_reload),
    .gap(gap), .pulses(pulses), .faults(faults));

  task close_out;
    $display("errors=%0d compares=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; an idle edge first so psel is never re-raised
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_errors++;
      close_out;
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  task wait_pulses(input int target);
    int n;
    n = 0;
    while (pulses < target && n < 5000)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (pulses < target)
    begin
      n_errors++;
      close_out;
    end
  endtask

  // Watchdog against a hang
  initial
  begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    close_out;
  end

  initial
  begin
    repeat (6) @(posedge sys_clk);
    sys_rst <= 1'b0;
    rd(`PMT_ADDR_COUNT, 32'h0);
    rd(`PMT_ADDR_PERIOD, 32'hff);
    rd(`PMT_ADDR_CONTROL, 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(`PMT_ADDR_CONTROL, 32'hff);
    rd(`PMT_ADDR_CONTROL, 32'h7f);
    // Stopped timer keeps count across a control write
    wr(`PMT_ADDR_CONTROL, 32'h0);
    wr(`PMT_ADDR_COUNT, 32'h5a);
    rd(`PMT_ADDR_COUNT, 32'h5a);
    p0 = pulses;
    wr(`PMT_ADDR_CONTROL, 32'h03);
    repeat (300) @(posedge sys_clk);
    rd(`PMT_ADDR_COUNT, 32'h5a);
    chk(pulses, p0);
    // Period for every prescale code
    wr(`PMT_ADDR_PERIOD, 32'h1);
    rd(`PMT_ADDR_PERIOD, 32'h1);
    for (i = 0; i < 4; i++)
    begin
      wr(`PMT_ADDR_CONTROL, 32'h4 | i);
      wait_pulses(pulses + 3);
      chk(gap, 8 << (2 * i));
    end
    // Sleep freezes the running timer
    sleep <= 1'b1;
    apb(1'b0, `PMT_ADDR_COUNT, 32'h0);
    p0 = pulses;
    repeat (1100) @(posedge sys_clk);
    rd(`PMT_ADDR_COUNT, q);
    chk(pulses, p0);
    sleep <= 1'b0;
    // Postscaler ratio, flag and gating
    wr(`PMT_ADDR_IRQ_EN, 32'h2);
    wr(`PMT_ADDR_PERIOD, 32'h7);
    for (i = 0; i < 3; i++)
    begin
      wr(`PMT_ADDR_CONTROL, 32'h0);
      wr(`PMT_ADDR_COUNT, 32'h0);
      wr(`PMT_ADDR_IRQ_REQ, 32'h0);
      p0 = pulses;
      wr(`PMT_ADDR_CONTROL, (codes[i] << 3) | 32'h4);
      wait_pulses(p0 + codes[i]);
      rd(`PMT_ADDR_IRQ_REQ, 32'h0);
      wait_pulses(p0 + codes[i] + 1);
      repeat (3) @(posedge sys_clk);
      rd(`PMT_ADDR_IRQ_REQ, 32'h2);
      chk({31'h0, match_irq}, 32'h1);
      if (codes[i] != 0)
        chk(gap, 32);
    end
    // Count write mid-ratio restarts the postscaler
    wr(`PMT_ADDR_CONTROL, 32'h0);
    wr(`PMT_ADDR_COUNT, 32'h0);
    wr(`PMT_ADDR_IRQ_REQ, 32'h0);
    p0 = pulses;
    wr(`PMT_ADDR_CONTROL, 32'h1c);
    wait_pulses(p0 + 2);
    wr(`PMT_ADDR_COUNT, 32'h0);
    wait_pulses(p0 + 5);
    rd(`PMT_ADDR_IRQ_REQ, 32'h0);
    wait_pulses(p0 + 6);
    repeat (3) @(posedge sys_clk);
    rd(`PMT_ADDR_IRQ_REQ, 32'h2);
    wr(`PMT_ADDR_IRQ_EN, 32'h0);
    @(posedge sys_clk);
    chk({31'h0, match_irq}, 32'h0);
    rd(`PMT_ADDR_IRQ_REQ, 32'h2);
    wr(`PMT_ADDR_IRQ_REQ, 32'h0);
    rd(`PMT_ADDR_IRQ_REQ, 32'h0);
    // Second reset source
    @(posedge sys_clk);
    soft_rst <= 1'b1;
    @(posedge sys_clk);
    soft_rst <= 1'b0;
    rd(`PMT_ADDR_COUNT, 32'h0);
    rd(`PMT_ADDR_PERIOD, 32'hff);
    rd(`PMT_ADDR_CONTROL, 32'h0);
    chk(faults, 0);
    close_out;
  end
endmodule // testbench
